// *** logic/scm_pkg.sv ***
// shared constants and types of the standby and clock mode controller
package scm_pkg;
	// clock rates
	localparam int unsigned CORE_CLK_HZ = 100_000_000;
	localparam int unsigned HIGH_FREQ_CLOCK_HZ = 16_000_000;
	localparam int unsigned LOW_FREQ_CLOCK_HZ = 32_768;
	// oscillator tick periods in core cycles, rounded down, at least one
	localparam int unsigned FAST_TICK_CYC = (CORE_CLK_HZ / HIGH_FREQ_CLOCK_HZ) < 1 ? 1 :
		(CORE_CLK_HZ / HIGH_FREQ_CLOCK_HZ);
	localparam int unsigned SLOW_TICK_CYC = (CORE_CLK_HZ / LOW_FREQ_CLOCK_HZ) < 1 ? 1 :
		(CORE_CLK_HZ / LOW_FREQ_CLOCK_HZ);
	// timing generator: 2-stage prescaler plus 21-stage divider
	localparam int unsigned TG_WIDTH = 23;
	localparam int unsigned MACHINE_STATES = 4;
	// register byte offsets
	localparam logic [7:0] SYS_CTRL_OFS = 8'h00;
	localparam logic [7:0] TIME_BASE_CTRL_OFS = 8'h04;
	localparam logic [7:0] MODE_STATUS_OFS = 8'h08;
	localparam logic [7:0] KEY_WAKE_EN_OFS = 8'h0c;
	// system control fields
	localparam int unsigned SC_STOP_BIT = 0;
	localparam int unsigned SC_PHALT_BIT = 1;
	localparam int unsigned SC_THALT_BIT = 2;
	localparam int unsigned SC_SLOWSYS_BIT = 3;
	localparam int unsigned SC_FASTEN_BIT = 4;
	localparam int unsigned SC_SLOWEN_BIT = 5;
	localparam logic SC_FASTEN_RST = 1'b1;
	localparam logic SC_SLOWEN_RST = 1'b0;
	localparam logic SC_SLOWSYS_RST = 1'b0;
	localparam logic [2:0] TBT_SEL_RST = 3'h0;
	localparam logic [3:0] KEY_WAKE_EN_RST = 4'h0;
	// divider bit picked for each tbt_source_select code
	localparam int unsigned TBT_TAP [8] = '{22, 20, 15, 13, 12, 11, 10, 8};
	// htrans codes
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [3:0] {
		FAST_RUN_SINGLE = 4'h0,
		FAST_RUN_DUAL = 4'h1,
		SLOW_FAST_OSC_ON = 4'h2,
		SLOW_FAST_OSC_OFF = 4'h3,
		FAST_TIMER_ONLY_HALT = 4'h4,
		FAST_PERIPHERAL_HALT = 4'h5,
		DUAL_PERIPHERAL_HALT = 4'h6,
		SLOW_TIMER_ONLY_HALT = 4'h7,
		SLOW_PERIPHERAL_HALT = 4'h8,
		SLOW_DUAL_PERIPHERAL_HALT = 4'h9,
		STOP_MODE = 4'ha
	} scm_mode_e;
endpackage : scm_pkg

// *** logic/scm_tg_if.sv ***
// link between the mode controller and its timing generator
`timescale 1ns/100ps
interface scm_tg_if;
	logic base_tick;
	logic clear;
	logic [2:0] tap_sel;
	logic tbt_src;
	logic [22:0] count;
	modport ctrl (output base_tick, output clear, output tap_sel, input tbt_src, input count);
	modport gen (input base_tick, input clear, input tap_sel, output tbt_src, output count);
endinterface : scm_tg_if

// *** logic/scm_timing_gen.sv ***
// prescaler and divider chain of the timing generator
`timescale 1ns/100ps
module scm_timing_gen import scm_pkg::*; #(
	parameter int unsigned WIDTH = TG_WIDTH
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// controller side
	scm_tg_if.gen tg
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic src;
	} scm_tg_s;

	scm_tg_s st_reg;
	scm_tg_s st_next;

	if (WIDTH != TG_WIDTH) begin : g_bad_width
		$error("timing generator width must match the tap table");
	end

	always_comb begin
		st_next = st_reg;
		if (tg.clear) begin
			st_next.cnt = '0;
		end else if (tg.base_tick) begin
			st_next.cnt = st_reg.cnt + WIDTH'(1);
		end
		st_next.src = st_next.cnt[TBT_TAP[tg.tap_sel]];
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tg.tbt_src = st_reg.src;
	assign tg.count = st_reg.cnt;
endmodule : scm_timing_gen

// *** logic/scm_ctrl.sv ***
// standby and clock mode controller with its register slave
`timescale 1ns/100ps
module scm_ctrl import scm_pkg::*; #(
	parameter int unsigned FAST_TICK = FAST_TICK_CYC,
	parameter int unsigned SLOW_TICK = SLOW_TICK_CYC,
	parameter int unsigned KEY_CH = 4
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// wakeup sources
	input wire logic irq_req_i,
	input wire logic interrupt_master_flag_i,
	input wire logic stop_release_i,
	input wire logic [KEY_CH-1:0] key_wakeup_inputs_i,
	// clock enables to cpu and peripherals
	output logic cpu_clk_en_o,
	output logic periph_fast_en_o,
	output logic periph_slow_en_o,
	output logic tbt_clk_en_o,
	output logic [1:0] machine_state_o,
	// oscillator and mode state
	output logic fast_osc_run_o,
	output logic slow_osc_run_o,
	output logic [3:0] mode_o,
	// resume handling towards the cpu
	output logic irq_service_o,
	output logic resume_next_o
);
	typedef struct packed {
		scm_mode_e mode;
		scm_mode_e ret_mode;
		logic fast_en;
		logic slow_en;
		logic slow_sys;
		logic [2:0] tbt_sel;
		logic [KEY_CH-1:0] key_en;
		logic [15:0] fast_cnt;
		logic [15:0] slow_cnt;
		logic [1:0] mstate;
		logic tbt_src_d;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
		logic cpu_en;
		logic pf_en;
		logic ps_en;
		logic tbt_en;
		logic irq_svc;
		logic resume;
	} scm_ctrl_s;

	scm_ctrl_s st_reg;
	scm_ctrl_s st_next;
	scm_tg_if tg_if ();

	logic fast_tick;
	logic slow_tick;
	logic fast_osc_on;
	logic slow_osc_on;
	logic addr_phase;
	logic tbt_fall;
	logic stop_wake;
	logic sc_wr;
	scm_mode_e run_target;
	logic [31:0] wd;

	if (FAST_TICK < 1 || FAST_TICK > 65535 || SLOW_TICK < 1 || SLOW_TICK > 65535) begin : g_bad_tick
		$error("oscillator tick periods must fit 16 bits and be at least one");
	end
	if (KEY_CH != 4) begin : g_bad_keys
		$error("key wakeup channel count must be four");
	end

	scm_timing_gen #(
		.WIDTH(TG_WIDTH)
	) u_tg (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.tg(tg_if.gen)
	);

	// oscillators as enable pulses; a stopped oscillator gives no tick
	always_comb begin
		fast_osc_on = !(st_reg.mode inside {STOP_MODE, SLOW_FAST_OSC_OFF, SLOW_PERIPHERAL_HALT}) &&
			!(st_reg.mode == SLOW_TIMER_ONLY_HALT && !st_reg.fast_en);
		slow_osc_on = st_reg.slow_en && st_reg.mode != STOP_MODE;
		fast_tick = fast_osc_on && st_reg.fast_cnt == 16'(FAST_TICK - 1);
		slow_tick = slow_osc_on && st_reg.slow_cnt == 16'(SLOW_TICK - 1);
		addr_phase = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;
		tbt_fall = st_reg.tbt_src_d && !tg_if.tbt_src;
		stop_wake = stop_release_i || |(key_wakeup_inputs_i & st_reg.key_en);
		sc_wr = st_reg.wr_pend && st_reg.wr_addr == SYS_CTRL_OFS;
		wd = hwdata_i;
		if (!wd[SC_SLOWEN_BIT]) begin
			run_target = FAST_RUN_SINGLE;
		end else if (!wd[SC_SLOWSYS_BIT]) begin
			run_target = FAST_RUN_DUAL;
		end else if (wd[SC_FASTEN_BIT]) begin
			run_target = SLOW_FAST_OSC_ON;
		end else begin
			run_target = SLOW_FAST_OSC_OFF;
		end
	end

	// the divider runs from the slow clock in slow modes, fast clock otherwise
	assign tg_if.base_tick = (st_reg.mode inside {SLOW_FAST_OSC_OFF, SLOW_FAST_OSC_ON, SLOW_TIMER_ONLY_HALT,
		SLOW_PERIPHERAL_HALT, SLOW_DUAL_PERIPHERAL_HALT}) ? slow_tick : fast_tick;
	// clear only on a real stop entry or release; a stop write ignored in a halt leaves the divider alone
	assign tg_if.clear = (st_next.mode == STOP_MODE) != (st_reg.mode == STOP_MODE);
	assign tg_if.tap_sel = st_reg.tbt_sel;

	always_comb begin
		st_next = st_reg;
		st_next.irq_svc = 1'b0;
		st_next.resume = 1'b0;
		st_next.fast_cnt = fast_tick || !fast_osc_on ? 16'h0000 : st_reg.fast_cnt + 16'h0001;
		st_next.slow_cnt = slow_tick || !slow_osc_on ? 16'h0000 : st_reg.slow_cnt + 16'h0001;
		st_next.tbt_src_d = tg_if.tbt_src;

		// bus: capture address phase, apply write data in the data phase
		st_next.wr_pend = addr_phase && hwrite_i;
		if (addr_phase) begin
			st_next.wr_addr = haddr_i[7:0];
		end
		if (addr_phase && !hwrite_i) begin
			st_next.rdata = 32'h0000_0000;
			unique case (haddr_i[7:0])
				SYS_CTRL_OFS: begin
					st_next.rdata[SC_SLOWSYS_BIT] = st_reg.slow_sys;
					st_next.rdata[SC_FASTEN_BIT] = st_reg.fast_en;
					st_next.rdata[SC_SLOWEN_BIT] = st_reg.slow_en;
				end
				TIME_BASE_CTRL_OFS: st_next.rdata[2:0] = st_reg.tbt_sel;
				MODE_STATUS_OFS: st_next.rdata[3:0] = st_reg.mode;
				KEY_WAKE_EN_OFS: st_next.rdata[KEY_CH-1:0] = st_reg.key_en;
				default: st_next.rdata = 32'h0000_0000;
			endcase
		end
		if (st_reg.wr_pend && st_reg.wr_addr == TIME_BASE_CTRL_OFS) begin
			st_next.tbt_sel = wd[2:0];
		end
		if (st_reg.wr_pend && st_reg.wr_addr == KEY_WAKE_EN_OFS) begin
			st_next.key_en = wd[KEY_CH-1:0];
		end

		// mode changes only on control writes or wakeup events
		unique case (st_reg.mode)
			FAST_RUN_SINGLE, FAST_RUN_DUAL, SLOW_FAST_OSC_ON, SLOW_FAST_OSC_OFF: begin
				if (sc_wr) begin
					st_next.slow_en = wd[SC_SLOWEN_BIT];
					st_next.slow_sys = wd[SC_SLOWSYS_BIT] && wd[SC_SLOWEN_BIT];
					st_next.fast_en = wd[SC_FASTEN_BIT] || !(wd[SC_SLOWSYS_BIT] && wd[SC_SLOWEN_BIT]);
					st_next.ret_mode = run_target;
					if (wd[SC_STOP_BIT]) begin
						st_next.mode = STOP_MODE;
					end else if (wd[SC_THALT_BIT]) begin
						st_next.mode = run_target inside {SLOW_FAST_OSC_ON, SLOW_FAST_OSC_OFF} ?
							SLOW_TIMER_ONLY_HALT : FAST_TIMER_ONLY_HALT;
					end else if (wd[SC_PHALT_BIT]) begin
						unique case (run_target)
							FAST_RUN_SINGLE: st_next.mode = FAST_PERIPHERAL_HALT;
							FAST_RUN_DUAL: st_next.mode = DUAL_PERIPHERAL_HALT;
							SLOW_FAST_OSC_OFF: st_next.mode = SLOW_PERIPHERAL_HALT;
							default: st_next.mode = SLOW_DUAL_PERIPHERAL_HALT;
						endcase
					end else begin
						st_next.mode = run_target;
					end
				end
			end
			FAST_TIMER_ONLY_HALT, SLOW_TIMER_ONLY_HALT: begin
				if (tbt_fall) begin
					st_next.mode = st_reg.ret_mode;
				end
			end
			FAST_PERIPHERAL_HALT, DUAL_PERIPHERAL_HALT, SLOW_PERIPHERAL_HALT, SLOW_DUAL_PERIPHERAL_HALT: begin
				if (irq_req_i) begin
					st_next.mode = st_reg.ret_mode;
					st_next.irq_svc = interrupt_master_flag_i;
					st_next.resume = !interrupt_master_flag_i;
				end
			end
			STOP_MODE: begin
				if (stop_wake) begin
					st_next.mode = st_reg.ret_mode;
				end
			end
			default: st_next.mode = FAST_RUN_SINGLE;
		endcase

		// clock gating per mode, registered onto the outputs
		st_next.cpu_en = 1'b0;
		st_next.pf_en = 1'b0;
		st_next.ps_en = 1'b0;
		st_next.tbt_en = 1'b0;
		unique case (st_reg.mode)
			FAST_RUN_SINGLE, FAST_RUN_DUAL: begin
				st_next.cpu_en = fast_tick;
				st_next.pf_en = fast_tick;
				st_next.ps_en = slow_tick;
				st_next.tbt_en = tg_if.base_tick;
			end
			SLOW_FAST_OSC_ON, SLOW_FAST_OSC_OFF: begin
				st_next.cpu_en = slow_tick;
				st_next.ps_en = slow_tick;
				st_next.tbt_en = tg_if.base_tick;
			end
			FAST_TIMER_ONLY_HALT, SLOW_TIMER_ONLY_HALT: begin
				st_next.tbt_en = tg_if.base_tick;
			end
			FAST_PERIPHERAL_HALT: begin
				st_next.pf_en = fast_tick;
				st_next.tbt_en = tg_if.base_tick;
			end
			DUAL_PERIPHERAL_HALT, SLOW_DUAL_PERIPHERAL_HALT: begin
				st_next.pf_en = fast_tick;
				st_next.ps_en = slow_tick;
				st_next.tbt_en = tg_if.base_tick;
			end
			SLOW_PERIPHERAL_HALT: begin
				st_next.ps_en = slow_tick;
				st_next.tbt_en = tg_if.base_tick;
			end
			default: begin
				st_next.cpu_en = 1'b0;
			end
		endcase
		if (st_next.cpu_en) begin
			st_next.mstate = st_reg.mstate + 2'h1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
			st_reg.mode <= FAST_RUN_SINGLE;
			st_reg.ret_mode <= FAST_RUN_SINGLE;
			st_reg.fast_en <= SC_FASTEN_RST;
			st_reg.slow_en <= SC_SLOWEN_RST;
			st_reg.slow_sys <= SC_SLOWSYS_RST;
			st_reg.tbt_sel <= TBT_SEL_RST;
			st_reg.key_en <= KEY_WAKE_EN_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// zero wait state slave, always OKAY
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
			fast_osc_run_o <= 1'b1;
			slow_osc_run_o <= 1'b0;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
			fast_osc_run_o <= !(st_next.mode inside {STOP_MODE, SLOW_FAST_OSC_OFF, SLOW_PERIPHERAL_HALT}) &&
				!(st_next.mode == SLOW_TIMER_ONLY_HALT && !st_next.fast_en);
			slow_osc_run_o <= st_next.slow_en && st_next.mode != STOP_MODE;
		end
	end

	assign hrdata_o = st_reg.rdata;
	assign cpu_clk_en_o = st_reg.cpu_en;
	assign periph_fast_en_o = st_reg.pf_en;
	assign periph_slow_en_o = st_reg.ps_en;
	assign tbt_clk_en_o = st_reg.tbt_en;
	assign machine_state_o = st_reg.mstate;
	assign mode_o = st_reg.mode;
	assign irq_service_o = st_reg.irq_svc;
	assign resume_next_o = st_reg.resume;
endmodule : scm_ctrl

// *** verification/scm_ctrl_sva.sv ***
// concurrent checks on the mode controller's clock gating and wakeups
`timescale 1ns/100ps
module scm_ctrl_sva import scm_pkg::*; (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// wakeup inputs
	input wire logic irq_req_i,
	input wire logic interrupt_master_flag_i,
	input wire logic stop_release_i,
	// observed outputs
	input wire logic cpu_clk_en_o,
	input wire logic periph_fast_en_o,
	input wire logic periph_slow_en_o,
	input wire logic tbt_clk_en_o,
	input wire logic [1:0] machine_state_o,
	input wire logic fast_osc_run_o,
	input wire logic slow_osc_run_o,
	input wire logic [3:0] mode_o,
	input wire logic irq_service_o,
	input wire logic resume_next_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	logic any_clk;
	logic phalt;
	assign any_clk = cpu_clk_en_o | periph_fast_en_o | periph_slow_en_o | tbt_clk_en_o;
	assign phalt = mode_o inside {FAST_PERIPHERAL_HALT, DUAL_PERIPHERAL_HALT, SLOW_PERIPHERAL_HALT,
		SLOW_DUAL_PERIPHERAL_HALT};
	// registered outputs may trail a mode change by one cycle, hence the stable guard
	a_stop_no_clock: assert property ($stable(mode_o) && mode_o == STOP_MODE |-> !any_clk && !fast_osc_run_o && !slow_osc_run_o) else $error("clock or oscillator alive in stop");
	a_slow_off_fast: assert property ($stable(mode_o) && mode_o == SLOW_FAST_OSC_OFF |-> !fast_osc_run_o && slow_osc_run_o && !periph_fast_en_o) else $error("fast clock alive in slow osc off");
	a_slow_on_osc: assert property ($stable(mode_o) && mode_o == SLOW_FAST_OSC_ON |-> fast_osc_run_o && slow_osc_run_o) else $error("oscillator off in slow osc on");
	a_timer_halt_gate: assert property ($stable(mode_o) && mode_o inside {FAST_TIMER_ONLY_HALT, SLOW_TIMER_ONLY_HALT} |-> !cpu_clk_en_o && !periph_fast_en_o && !periph_slow_en_o) else $error("clock leaks in timer halt");
	a_fast_halt_gate: assert property ($stable(mode_o) && mode_o == FAST_PERIPHERAL_HALT |-> !cpu_clk_en_o && !periph_slow_en_o) else $error("wrong clocks in fast halt");
	a_dual_halt_osc: assert property ($stable(mode_o) && mode_o inside {DUAL_PERIPHERAL_HALT, SLOW_DUAL_PERIPHERAL_HALT} |-> !cpu_clk_en_o && fast_osc_run_o && slow_osc_run_o) else $error("wrong clocks in dual halt");
	a_slow_halt_gate: assert property ($stable(mode_o) && mode_o == SLOW_PERIPHERAL_HALT |-> !cpu_clk_en_o && !periph_fast_en_o && !fast_osc_run_o) else $error("wrong clocks in slow halt");
	a_irq_release: assert property (phalt && irq_req_i |=> !phalt && irq_service_o == $past(interrupt_master_flag_i) && resume_next_o == !$past(interrupt_master_flag_i)) else $error("halt not released by interrupt");
	a_stop_release: assert property (mode_o == STOP_MODE && stop_release_i |=> mode_o == FAST_RUN_SINGLE) else $error("stop not released");
	a_reset_run: assert property ($fell(rst_i) |-> mode_o == FAST_RUN_SINGLE && fast_osc_run_o && !slow_osc_run_o) else $error("wrong state after reset");
	a_machine_step: assert property (!$past(rst_i) && $changed(machine_state_o) |-> machine_state_o == $past(machine_state_o) + 2'h1) else $error("machine state skipped");
	c_stop_left: cover property (mode_o == STOP_MODE ##1 mode_o == FAST_RUN_SINGLE);
	c_irq_served: cover property (irq_service_o);
	c_resume_next: cover property (resume_next_o);
	c_timer_done: cover property (mode_o == FAST_TIMER_ONLY_HALT ##1 mode_o == FAST_RUN_SINGLE);
endmodule : scm_ctrl_sva

bind scm_ctrl scm_ctrl_sva u_sva (.core_clk_i(core_clk_i), .rst_i(rst_i), .irq_req_i(irq_req_i),
	.interrupt_master_flag_i(interrupt_master_flag_i), .stop_release_i(stop_release_i),
	.cpu_clk_en_o(cpu_clk_en_o), .periph_fast_en_o(periph_fast_en_o), .periph_slow_en_o(periph_slow_en_o),
	.tbt_clk_en_o(tbt_clk_en_o), .machine_state_o(machine_state_o), .fast_osc_run_o(fast_osc_run_o),
	.slow_osc_run_o(slow_osc_run_o), .mode_o(mode_o), .irq_service_o(irq_service_o),
	.resume_next_o(resume_next_o));

// *** verification/scm_periph_model.sv ***
// behavioural peripheral that raises an interrupt from its gated clock
`timescale 1ns/100ps
module scm_periph_model (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// gated clocks from the controller
	input wire logic cpu_clk_en_i,
	input wire logic periph_fast_en_i,
	input wire logic periph_slow_en_i,
	// bench control
	input wire logic arm_i,
	input wire logic [2:0] delay_i,
	// interrupt towards the controller
	output logic irq_req_o
);
	logic [2:0] tick_cnt_reg;
	// request held until the cpu runs again, like an interrupt latch
	always_ff @(posedge core_clk_i) begin
		if (rst_i || !arm_i) begin
			tick_cnt_reg <= 3'h0;
			irq_req_o <= 1'b0;
		end else if (irq_req_o && cpu_clk_en_i) begin
			irq_req_o <= 1'b0;
		end else if ((periph_fast_en_i || periph_slow_en_i) && !irq_req_o) begin
			// only a clocked peripheral can count, so a halt without clocks never wakes
			if (tick_cnt_reg == delay_i)
				irq_req_o <= 1'b1;
			else
				tick_cnt_reg <= tick_cnt_reg + 3'h1;
		end
	end
endmodule : scm_periph_model

// *** verification/scm_ctrl_tb_top.sv ***
// self-checking bench of the standby and clock mode controller
`timescale 1ns/100ps
module scm_ctrl_tb_top import scm_pkg::*; ;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic hwrite, irq_flag, stop_rel, arm, rd_phase, hready, hresp, irq_req, cpu_en, pf_en, ps_en;
	logic fast_run, slow_run, isrv, rnext, tbt_en;
	logic [1:0] htrans, mstate;
	logic [2:0] dly;
	logic [3:0] keys, mode;
	logic [31:0] haddr, hwdata, hrdata, rnd;
	int failures = 0;
	int checks_done = 0;
	int k;
	int cpu_pulses = 0;
	int tbt_pulses = 0;
	int t0;
	logic [31:0] rd_q[$];
	logic [1:0] wk_q[$];
	logic [31:0] run_val [6] = '{32'h30, 32'h38, 32'h28, 32'h38, 32'h30, 32'h10};
	logic [3:0] run_mode [6] = '{FAST_RUN_DUAL, SLOW_FAST_OSC_ON, SLOW_FAST_OSC_OFF, SLOW_FAST_OSC_ON,
		FAST_RUN_DUAL, FAST_RUN_SINGLE};
	int ph_idx [4] = '{5, 0, 2, 1};
	logic [3:0] ph_mode [4] = '{FAST_PERIPHERAL_HALT, DUAL_PERIPHERAL_HALT, SLOW_PERIPHERAL_HALT,
		SLOW_DUAL_PERIPHERAL_HALT};

	always #5 core_clk_i = ~core_clk_i;

	scm_ctrl #(.FAST_TICK(2), .SLOW_TICK(5)) uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .hsel_i(1'b1),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .irq_req_i(irq_req),
		.interrupt_master_flag_i(irq_flag), .stop_release_i(stop_rel), .key_wakeup_inputs_i(keys),
		.cpu_clk_en_o(cpu_en), .periph_fast_en_o(pf_en), .periph_slow_en_o(ps_en), .tbt_clk_en_o(tbt_en),
		.machine_state_o(mstate), .fast_osc_run_o(fast_run), .slow_osc_run_o(slow_run), .mode_o(mode),
		.irq_service_o(isrv), .resume_next_o(rnext));

	scm_periph_model u_periph (.core_clk_i(core_clk_i), .rst_i(rst_i), .cpu_clk_en_i(cpu_en),
		.periph_fast_en_i(pf_en), .periph_slow_en_i(ps_en), .arm_i(arm), .delay_i(dly), .irq_req_o(irq_req));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			give_verdict();
		end
	endtask : wait_ready

	// called just after a clock edge; the next transfer may start at the edge that ends this one
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		haddr <= {24'h0, a};
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		rd_phase <= !wr;
		wait_ready();
		rd_phase <= 1'b0;
	endtask : bus

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		rd_q.push_back(exp);
		bus(1'b0, a, 32'h0);
	endtask : rd

	task automatic wait_mode(input logic [3:0] m, input int bound);
		int n;
		n = 0;
		while (mode !== m && n < bound) begin
			@(posedge core_clk_i);
			n++;
		end
		check("mode", {28'h0, mode}, {28'h0, m});
		if (n >= bound)
			give_verdict();
	endtask : wait_mode

	always @(posedge core_clk_i) begin
		// pulse counts give the expected machine state and show that the timer is clocked
		if (rst_i) begin
			cpu_pulses <= 0;
		end else if (cpu_en) begin
			cpu_pulses <= cpu_pulses + 1;
		end
		if (tbt_en) begin
			tbt_pulses <= tbt_pulses + 1;
		end
		if (rd_phase && hready) begin
			check("hresp", {31'h0, hresp}, 32'h0);
			if (rd_q.size() == 0)
				check("read note", 32'h1, 32'h0);
			else
				check("read data", hrdata, rd_q.pop_front());
		end
		if ((isrv | rnext) === 1'b1) begin
			if (wk_q.size() == 0)
				check("wake note", 32'h1, 32'h0);
			else
				check("wake", {30'h0, isrv, rnext}, {30'h0, wk_q.pop_front()});
		end
	end

	initial begin
		{hwrite, irq_flag, stop_rel, arm, rd_phase, htrans, dly, keys, haddr, hwdata} = '0;
		void'($urandom(32'he095ed00));
		repeat (16) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rd(MODE_STATUS_OFS, 32'h0);
		rd(SYS_CTRL_OFS, 32'h10);
		rd(8'h10, 32'h0);
		$display("test reset done");
		foreach (run_val[i]) begin
			bus(1'b1, SYS_CTRL_OFS, run_val[i]);
			wait_mode(run_mode[i], 10);
			repeat (2) @(posedge core_clk_i);
			check("fast osc", {31'h0, fast_run}, {31'h0, run_val[i][4]});
			check("machine state", {30'h0, mstate}, (cpu_pulses + cpu_en) % 4);
			rd(MODE_STATUS_OFS, {28'h0, run_mode[i]});
		end
		$display("test run modes done");
		foreach (ph_idx[i]) begin
			k = ph_idx[i];
			rnd = $urandom;
			irq_flag <= rnd[0];
			dly <= rnd[3:1];
			bus(1'b1, SYS_CTRL_OFS, run_val[k] | 32'h2);
			wait_mode(ph_mode[i], 10);
			bus(1'b1, SYS_CTRL_OFS, 32'h11);
			repeat (3) @(posedge core_clk_i);
			check("halt kept", {28'h0, mode}, {28'h0, ph_mode[i]});
			wk_q.push_back({rnd[0], !rnd[0]});
			arm <= 1'b1;
			wait_mode(run_mode[k], 4000);
			arm <= 1'b0;
		end
		$display("test peripheral halts done");
		for (int t = 0; t < 2; t++) begin
			bus(1'b1, TIME_BASE_CTRL_OFS, 32'h7 - t);
			rd(TIME_BASE_CTRL_OFS, 32'h7 - t);
			bus(1'b1, SYS_CTRL_OFS, t ? 32'h2c : 32'h14);
			wait_mode(t ? SLOW_TIMER_ONLY_HALT : FAST_TIMER_ONLY_HALT, 10);
			t0 = tbt_pulses;
			wait_mode(t ? SLOW_FAST_OSC_OFF : FAST_RUN_SINGLE, 30000);
			check("timer clocked", {31'h0, tbt_pulses > t0}, 32'h1);
		end
		$display("test timer halts done");
		bus(1'b1, SYS_CTRL_OFS, 32'h11);
		wait_mode(STOP_MODE, 10);
		repeat (20) @(posedge core_clk_i);
		check("osc in stop", {30'h0, fast_run, slow_run}, 32'h0);
		stop_rel <= 1'b1;
		wait_mode(FAST_RUN_SINGLE, 5);
		stop_rel <= 1'b0;
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, KEY_WAKE_EN_OFS, 32'h1 << c);
			bus(1'b1, SYS_CTRL_OFS, 32'h11);
			wait_mode(STOP_MODE, 10);
			keys <= 4'hf ^ (4'h1 << c);
			repeat (4) @(posedge core_clk_i);
			check("key masked", {28'h0, mode}, {28'h0, STOP_MODE});
			keys <= 4'hf;
			wait_mode(FAST_RUN_SINGLE, 5);
			keys <= 4'h0;
		end
		$display("test stop and key wakeup done");
		bus(1'b1, SYS_CTRL_OFS, 32'h28);
		wait_mode(SLOW_FAST_OSC_OFF, 10);
		rst_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rd(MODE_STATUS_OFS, 32'h0);
		rd(SYS_CTRL_OFS, 32'h10);
		repeat (4) @(posedge core_clk_i);
		check("machine state", {30'h0, mstate}, (cpu_pulses + cpu_en) % 4);
		$display("test second reset done");
		give_verdict();
	end
endmodule : scm_ctrl_tb_top
